// ---- hw/adla_decoder.sv ----
// Top of the two programmable address decode arrays with port A tracking.
// Assumes pins come from the host bus unsynchronised; configuration and
// term programming ports are static non-volatile settings.
`timescale 1ns/1ps
module adla_decoder #(
    parameter bit PAGE_PRESENT = 1'b1,
    parameter bit RAM_PRESENT  = 1'b1
) (
    input  wire logic                                    clk_in,
    input  wire logic                                    arst_n_in,
    input  wire logic [adla_pkg::N_ADDR-1:0]             addr_hi_in,
    input  wire logic                                    top_addr_or_sleep_input_in,
    input  wire logic [adla_pkg::N_PAGE-1:0]             page_number_inputs_in,
    input  wire logic                                    read_strobe_input_in,
    input  wire logic                                    write_strobe_in,
    input  wire logic                                    addr_latch_strobe_in,
    input  wire logic                                    sleep_mode_sel_in,
    input  wire logic                                    port_a_track_enable_in,
    input  wire logic [adla_pkg::N_PORTC-1:0]            port_c_select_route_in,
    input  wire logic [adla_pkg::NTERM*adla_pkg::NIN-1:0] term_care_in,
    input  wire logic [adla_pkg::NTERM*adla_pkg::NIN-1:0] term_pol_in,
    input  wire logic [adla_pkg::NTERM-1:0]              term_used_in,
    input  wire logic [adla_pkg::N_PORTC-1:0]            port_c_pins_in,
    output logic      [adla_pkg::N_PORTC-1:0]            port_c_pins_out,
    output logic      [adla_pkg::N_PORTC-1:0]            port_c_pins_oe_out,
    input  wire logic [adla_pkg::N_BYTE-1:0]             port_a_pins_in,
    output logic      [adla_pkg::N_BYTE-1:0]             port_a_pins_out,
    output logic                                         port_a_pins_oe_out,
    input  wire logic [adla_pkg::N_BYTE-1:0]             low_addr_data_pins_in,
    output logic      [adla_pkg::N_BYTE-1:0]             low_addr_data_pins_out,
    output logic                                         low_addr_data_pins_oe_out,
    output logic      [adla_pkg::N_BANK-1:0]             memory_bank_selects_out,
    output logic                                         static_ram_select_out,
    output logic                                         io_port_select_out,
    output logic                                         track_in_select_out,
    output logic                                         track_address_out_select_out,
    output logic                                         track_data_out_select_out,
    output logic      [adla_pkg::N_WIDE-1:0]             wide_port_b_selects_out,
    output logic      [adla_pkg::N_NARW-1:0]             narrow_port_b_selects_out,
    output logic      [adla_pkg::N_PORTC-1:0]            port_c_selects_out,
    output logic                                         standby_out
);
    import adla_pkg::*;

    typedef struct packed {
        adla_pins_t          s1;
        adla_pins_t          s2;
        logic [N_BANK-1:0]   bank;
        logic                ram;
        logic                io;
        logic                tin;
        logic                taout;
        logic                tdout;
        logic [N_WIDE-1:0]   wide;
        logic [N_NARW-1:0]   narw;
        logic [N_PORTC-1:0]  pcs;
        logic [N_PORTC-1:0]  pc_out;
        logic [N_PORTC-1:0]  pc_oe;
        logic [N_BYTE-1:0]   pa_out;
        logic                pa_oe;
        logic [N_BYTE-1:0]   ad_out;
        logic                ad_oe;
        logic                standby;
    } adla_state_t;

    adla_state_t state_reg;
    adla_state_t state_next;
    logic [1:0]  rst_sync_reg;
    logic        rst_n;
    adla_pins_t  pins_now;
    logic        blank;
    logic        track_on;
    logic [N_PAGE-1:0]  page_lit;
    logic [N_PORTC-1:0] portc_lit;
    logic               top_lit;

    adla_term_if tif ();

    adla_term_array u_array (
        .tif (tif.array)
    );

    // Reset release through two flip-flops
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'h1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Raw pin bundle into the synchroniser
    assign pins_now.addr  = addr_hi_in;
    assign pins_now.portc = port_c_pins_in;
    assign pins_now.top   = top_addr_or_sleep_input_in;
    assign pins_now.page  = page_number_inputs_in;
    assign pins_now.rd    = read_strobe_input_in;
    assign pins_now.wr    = write_strobe_in;
    assign pins_now.ale   = addr_latch_strobe_in;
    assign pins_now.porta = port_a_pins_in;
    assign pins_now.ad    = low_addr_data_pins_in;

    // Sleep blanking, track enable and literal conditioning
    assign blank     = sleep_mode_sel_in & state_reg.s2.top;
    assign top_lit   = sleep_mode_sel_in ? 1'h0 : state_reg.s2.top;
    assign page_lit  = PAGE_PRESENT ? state_reg.s2.page : 4'h0;
    assign portc_lit = state_reg.s2.portc & ~port_c_select_route_in;
    assign track_on  = port_a_track_enable_in;

    // Shared literal bus for both arrays; reset is deliberately absent
    assign tif.lit  = {state_reg.s2.ale, state_reg.s2.wr, state_reg.s2.rd,
                       page_lit, top_lit, portc_lit, state_reg.s2.addr};
    assign tif.care = term_care_in;
    assign tif.pol  = term_pol_in;
    assign tif.used = term_used_in;

    // Next state: synchroniser, array outputs, port drivers
    always_comb begin
        state_next    = state_reg;
        state_next.s1 = pins_now;
        state_next.s2 = state_reg.s1;
        state_next.bank  = tif.hit[TERM_BANK +: N_BANK] & {N_BANK{~blank}};
        state_next.ram   = RAM_PRESENT & tif.hit[TERM_RAM] & ~blank;
        state_next.io    = tif.hit[TERM_IO] & ~blank;
        state_next.tin   = tif.hit[TERM_TIN] & ~blank;
        state_next.taout = tif.hit[TERM_TAOUT] & ~blank;
        state_next.tdout = tif.hit[TERM_TDOUT] & ~blank;
        for (int i = 0; i < N_WIDE; i++) begin
            state_next.wide[i] = (|tif.hit[TERM_WIDE + i*WIDE_TERMS +: WIDE_TERMS]) & ~blank;
        end
        for (int i = 0; i < N_NARW; i++) begin
            state_next.narw[i] = (|tif.hit[TERM_NARW + i*NARW_TERMS +: NARW_TERMS]) & ~blank;
        end
        state_next.pcs    = tif.hit[TERM_PC +: N_PORTC] & {N_PORTC{~blank}};
        state_next.pc_out = state_next.pcs & port_c_select_route_in;
        state_next.pc_oe  = port_c_select_route_in;
        // Port A to bus on track-in read
        state_next.ad_oe  = track_on & state_next.tin & state_reg.s2.rd;
        state_next.ad_out = state_reg.s2.porta;
        // Bus address on latch strobe, or bus data on any track data out select, out through port A
        state_next.pa_oe  = track_on & ((state_next.taout & state_reg.s2.ale)
                                        | state_next.tdout);
        state_next.pa_out = state_reg.s2.ad;
        state_next.standby = blank;
    end

    // State register; reset clears every select and driver
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register
    assign memory_bank_selects_out      = state_reg.bank;
    assign static_ram_select_out        = state_reg.ram;
    assign io_port_select_out           = state_reg.io;
    assign track_in_select_out          = state_reg.tin;
    assign track_address_out_select_out = state_reg.taout;
    assign track_data_out_select_out    = state_reg.tdout;
    assign wide_port_b_selects_out      = state_reg.wide;
    assign narrow_port_b_selects_out    = state_reg.narw;
    assign port_c_selects_out           = state_reg.pcs;
    assign port_c_pins_out              = state_reg.pc_out;
    assign port_c_pins_oe_out           = state_reg.pc_oe;
    assign port_a_pins_out              = state_reg.pa_out;
    assign port_a_pins_oe_out           = state_reg.pa_oe;
    assign low_addr_data_pins_out       = state_reg.ad_out;
    assign low_addr_data_pins_oe_out    = state_reg.ad_oe;
    assign standby_out                  = state_reg.standby;

    // Checks on the decoder behaviour
    a_sleep_blanks: assert property (@(posedge clk_in) disable iff (!rst_n)
        blank |=> (standby_out && memory_bank_selects_out == 8'h00 && port_c_selects_out == 3'h0
                   && wide_port_b_selects_out == 4'h0 && !io_port_select_out && !port_a_pins_oe_out))
        else $error("sleep did not blank outputs");

    a_addr_mode_awake: assert property (@(posedge clk_in) disable iff (!rst_n)
        !sleep_mode_sel_in |=> !standby_out)
        else $error("standby entered in address mode");

    a_portc_literal: assert property (@(posedge clk_in) disable iff (!rst_n)
        tif.lit[LIT_PORTC +: N_PORTC] == (state_reg.s2.portc & ~port_c_select_route_in))
        else $error("port C literal wrong");

    a_reset_quiet: assert property (@(posedge clk_in)
        !rst_n |-> (memory_bank_selects_out == 8'h00 && !port_a_pins_oe_out
                    && !low_addr_data_pins_oe_out && port_c_pins_oe_out == 3'h0))
        else $error("output active during reset");

    a_bank_follows: assert property (@(posedge clk_in) disable iff (!rst_n)
        rst_n |=> memory_bank_selects_out == ($past(tif.hit[TERM_BANK +: N_BANK]) & {N_BANK{!$past(blank)}}))
        else $error("bank select mismatch");

    a_track_gate: assert property (@(posedge clk_in) disable iff (!rst_n)
        !track_on |=> (!port_a_pins_oe_out && !low_addr_data_pins_oe_out))
        else $error("port A driven outside track mode");

    a_track_read: assert property (@(posedge clk_in) disable iff (!rst_n)
        (track_on && tif.hit[TERM_TIN] && state_reg.s2.rd && !blank)
        |=> (low_addr_data_pins_oe_out && low_addr_data_pins_out == $past(state_reg.s2.porta)))
        else $error("track read path wrong");

    a_track_addr: assert property (@(posedge clk_in) disable iff (!rst_n)
        (track_on && tif.hit[TERM_TAOUT] && state_reg.s2.ale && !blank)
        |=> (port_a_pins_oe_out && port_a_pins_out == $past(state_reg.s2.ad)))
        else $error("track address out wrong");

    a_track_data: assert property (@(posedge clk_in) disable iff (!rst_n)
        (track_on && tif.hit[TERM_TDOUT] && !blank) |=> port_a_pins_oe_out)
        else $error("track data out missing");

    a_wide_sum: assert property (@(posedge clk_in) disable iff (!rst_n)
        (!blank && |tif.hit[TERM_WIDE +: WIDE_TERMS]) |=> wide_port_b_selects_out[0])
        else $error("wide select sum wrong");

    a_narrow_sum: assert property (@(posedge clk_in) disable iff (!rst_n)
        rst_n |=> narrow_port_b_selects_out[0] == ($past(|tif.hit[TERM_NARW +: NARW_TERMS]) && !$past(blank)))
        else $error("narrow select sum wrong");

    a_portc_route: assert property (@(posedge clk_in) disable iff (!rst_n)
        ##1 port_c_pins_out == ($past(port_c_select_route_in) & port_c_selects_out))
        else $error("port C routing wrong");

    c_sleep_entry: cover property (@(posedge clk_in) disable iff (!rst_n) $rose(standby_out));
    c_track_read:  cover property (@(posedge clk_in) disable iff (!rst_n) low_addr_data_pins_oe_out);
    c_track_addr:  cover property (@(posedge clk_in) disable iff (!rst_n) port_a_pins_oe_out);
    c_wide_hit:    cover property (@(posedge clk_in) disable iff (!rst_n) |wide_port_b_selects_out);
endmodule

// ---- hw/adla_pkg.sv ----
// Constants for the two programmable decode arrays: literal and term layout.
// Assumes one 200 MHz clock; every pin is sampled through two flip-flops.
package adla_pkg;

    // Literal positions on the shared term input bus
    localparam int NIN        = 16;
    localparam int LIT_ADDR   = 0;   // Address bits 11..15
    localparam int N_ADDR     = 5;
    localparam int LIT_PORTC  = 5;   // Port C pins, address bits 16..18
    localparam int N_PORTC    = 3;
    localparam int LIT_TOP    = 8;   // Top address bit or sleep input
    localparam int LIT_PAGE   = 9;   // Page number bits
    localparam int N_PAGE     = 4;
    localparam int LIT_RD     = 13;
    localparam int LIT_WR     = 14;
    localparam int LIT_ALE    = 15;

    // Product term layout across both arrays
    localparam int NTERM      = 40;
    localparam int N_BANK     = 8;
    localparam int TERM_BANK  = 0;
    localparam int TERM_RAM   = 8;
    localparam int TERM_IO    = 9;
    localparam int TERM_TIN   = 10;
    localparam int TERM_TAOUT = 11;
    localparam int TERM_TDOUT = 12;
    localparam int TERM_WIDE  = 13;  // Four selects of four terms each
    localparam int N_WIDE     = 4;
    localparam int WIDE_TERMS = 4;
    localparam int TERM_NARW  = 29;  // Four selects of two terms each
    localparam int N_NARW     = 4;
    localparam int NARW_TERMS = 2;
    localparam int TERM_PC    = 37;  // Three single-term port C selects

    localparam int N_BYTE     = 8;

    // Pin bundle passed through the input synchroniser
    typedef struct packed {
        logic [N_ADDR-1:0]  addr;
        logic [N_PORTC-1:0] portc;
        logic               top;
        logic [N_PAGE-1:0]  page;
        logic               rd;
        logic               wr;
        logic               ale;
        logic [N_BYTE-1:0]  porta;
        logic [N_BYTE-1:0]  ad;
    } adla_pins_t;

endpackage

// ---- hw/adla_term_array.sv ----
// Combinational product term array shared by both decode arrays.
// Assumes literals are already synchronised and programming is static.
`timescale 1ns/1ps
module adla_term_array (
    adla_term_if.array tif
);
    import adla_pkg::*;

    // One AND term per entry: a literal with care low is don't care, else it must equal pol
    genvar t;
    generate
        for (t = 0; t < NTERM; t++) begin : g_term
            assign tif.hit[t] = tif.used[t] &
                &(~tif.care[t*NIN +: NIN] | ~(tif.lit ^ tif.pol[t*NIN +: NIN]));
        end
    endgenerate
endmodule

// ---- hw/adla_term_if.sv ----
// Carrier between the decoder top and its product term array.
// Assumes the top drives literals and programming and reads the term hits.
`timescale 1ns/1ps
interface adla_term_if;
    import adla_pkg::*;

    logic [NIN-1:0]       lit;
    logic [NTERM*NIN-1:0] care;
    logic [NTERM*NIN-1:0] pol;
    logic [NTERM-1:0]     used;
    logic [NTERM-1:0]     hit;

    modport array (input lit, input care, input pol, input used, output hit);
    modport user  (output lit, output care, output pol, output used, input hit);
endinterface

// ---- verif/adla_decoder_tb.sv ----
// Self-checking bench for the two decode arrays with port A tracking.
// Assumes the three-cycle pin-to-output latency and term layout of the package.
`timescale 1ns/1ps
module adla_decoder_tb;
    import adla_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, sleep_sel = 1'b0, track_en = 1'b0;
    logic [2:0]          route = 3'b000;
    logic [NTERM*NIN-1:0] care = '0, pol = '0;
    logic [NTERM-1:0]    used = '0;
    logic [4:0]  h_addr;
    logic [3:0]  h_page;
    logic [2:0]  h_pc, pc_out, pc_oe, pc_sel, pc_wire;
    logic [7:0]  h_pa, h_ad, pa_out, ad_out, pa_wire, ad_wire, banks;
    logic [3:0]  wide, narw;
    logic        h_top, h_rd, h_wr, h_ale, pa_oe, ad_oe, ram, io, tin, taout, tdout, stby;
    logic [23:0] sel;
    int n_mismatch = 0, check_count = 0;

    // Clock and wire levels resolved from the decoder's enables; the host level shows when the decoder is off
    always #2.5 clk = ~clk;
    assign pc_wire = (pc_oe & pc_out) | (~pc_oe & h_pc);
    assign pa_wire = pa_oe ? pa_out : h_pa;
    assign ad_wire = ad_oe ? ad_out : h_ad;
    assign sel = {banks, ram, io, tin, taout, tdout, wide, narw, pc_sel};

    adla_host_model host (.clk_in(clk), .addr_out(h_addr), .top_out(h_top), .page_out(h_page), .rd_out(h_rd),
        .wr_out(h_wr), .ale_out(h_ale), .portc_out(h_pc), .porta_out(h_pa), .ad_out(h_ad));

    adla_decoder u_dut (.clk_in(clk), .arst_n_in(arst_n), .addr_hi_in(h_addr), .top_addr_or_sleep_input_in(h_top),
        .page_number_inputs_in(h_page), .read_strobe_input_in(h_rd), .write_strobe_in(h_wr),
        .addr_latch_strobe_in(h_ale), .sleep_mode_sel_in(sleep_sel), .port_a_track_enable_in(track_en),
        .port_c_select_route_in(route), .term_care_in(care), .term_pol_in(pol), .term_used_in(used),
        .port_c_pins_in(pc_wire), .port_c_pins_out(pc_out), .port_c_pins_oe_out(pc_oe),
        .port_a_pins_in(pa_wire), .port_a_pins_out(pa_out), .port_a_pins_oe_out(pa_oe),
        .low_addr_data_pins_in(ad_wire), .low_addr_data_pins_out(ad_out), .low_addr_data_pins_oe_out(ad_oe),
        .memory_bank_selects_out(banks), .static_ram_select_out(ram), .io_port_select_out(io),
        .track_in_select_out(tin), .track_address_out_select_out(taout), .track_data_out_select_out(tdout),
        .wide_port_b_selects_out(wide), .narrow_port_b_selects_out(narw), .port_c_selects_out(pc_sel),
        .standby_out(stby));

    // Program one term: literal mask and the level each cared literal must have
    task automatic prog(input int t, input logic [15:0] c, input logic [15:0] p);
        care[t*NIN +: NIN] = c;
        pol[t*NIN +: NIN]  = p;
        used[t]            = 1'b1;
    endtask

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Apply one bus state and wait out the three-cycle answer, plus bus turnaround settling
    task automatic go(input logic [4:0] a, input logic tp, input logic [3:0] pg, input logic r, input logic w,
                      input logic l, input logic [2:0] pc, input logic [7:0] pa, input logic [7:0] ad);
        @(posedge clk);
        #1;
        host.drive(a, tp, pg, r, w, l, pc, pa, 1'b1, ad);
        repeat (6) @(posedge clk);
        #1;
    endtask

    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Watchdog far beyond the fewer than two hundred cycles the tests need
    initial begin
        #50000;
        n_mismatch++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        for (int b = 0; b < N_BANK; b++) prog(TERM_BANK + b, 16'h001F, 16'(b));
        prog(TERM_RAM, 16'h1E00, 16'h1400);
        prog(TERM_IO, 16'h0100, 16'h0100);
        prog(TERM_TIN, 16'h2000, 16'h2000);
        prog(TERM_TAOUT, 16'h8000, 16'h8000);
        prog(TERM_TDOUT, 16'h6000, 16'h4000);
        for (int k = 0; k < WIDE_TERMS; k++) prog(TERM_WIDE + k, 16'h001F, 16'(16 + k));
        prog(TERM_NARW, 16'h001F, 16'h0014);
        prog(TERM_PC, 16'h0020, 16'h0020);
        prog(TERM_PC + 1, 16'h0000, 16'h0000);
        repeat (16) @(posedge clk);
        #1;
        arst_n = 1'b1;
        for (int b = 0; b < N_BANK; b++) begin
            go(5'(b), 0, 0, 0, 0, 0, 0, 0, 0);
            chk("bank selects", 24'h2 | (24'h1 << (16 + b)), sel);
        end
        for (int k = 0; k < WIDE_TERMS; k++) begin
            go(5'(16 + k), 0, 0, 0, 0, 0, 0, 0, 0);
            chk("wide select", 24'h82, sel);
        end
        go(20, 0, 0, 0, 0, 0, 0, 0, 0);
        chk("narrow select", 24'h0A, sel);
        go(21, 0, 0, 0, 0, 0, 0, 0, 0);
        chk("unused narrow term", 24'h2, sel);
        go(31, 0, 4'hA, 0, 0, 0, 3'b001, 0, 0);
        chk("ram and port c select", 24'h8003, sel);
        go(31, 1, 0, 0, 0, 0, 0, 0, 0);
        chk("top as address literal", 24'h4002, sel);
        route = 3'b010;
        go(31, 0, 0, 0, 0, 0, 3'b001, 0, 0);
        chk("port c oe", 3'b010, pc_oe);
        chk("port c out", 3'b010, pc_out);
        chk("port c unrouted select", 24'h3, sel);
        route = 3'b000;
        go(31, 0, 0, 1, 0, 0, 0, 8'h5A, 8'h00);
        chk("track off bus oe", 0, ad_oe);
        track_en = 1'b1;
        go(31, 0, 0, 1, 0, 0, 0, 8'h5A, 8'h00);
        chk("track in bus", 9'h15A, {ad_oe, ad_out});
        go(31, 0, 0, 0, 0, 1, 0, 8'h00, 8'h3C);
        chk("track addr out", {9'h13C, 24'h1002}, {pa_oe, pa_out, sel});
        go(31, 0, 0, 0, 1, 0, 0, 8'h00, 8'hC3);
        chk("track data out", {9'h1C3, 24'h0802}, {pa_oe, pa_out, sel});
        sleep_sel = 1'b1;
        go(31, 1, 4'hA, 0, 0, 0, 0, 0, 0);
        chk("sleep blanks selects", {stby, pa_oe, ad_oe, sel}, 27'h4000000);
        go(31, 0, 4'hA, 0, 0, 0, 0, 0, 0);
        chk("sleep pin low", {stby, sel}, 25'h8002);
        #1;
        arst_n = 1'b0;
        #1;
        chk("reset blanks outputs", {stby, pc_oe, pa_oe, ad_oe, sel}, 0);
        repeat (3) @(posedge clk);
        #1;
        arst_n = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk("after second reset", {stby, sel}, 25'h8002);
        tally_and_finish();
    end
endmodule

// ---- verif/adla_host_model.sv ----
// Host bus model: drives address, page, strobes, port C and both byte buses.
// Assumes the bench calls drive just after a rising edge of clk_in.
`timescale 1ns/1ps
module adla_host_model (
    input  wire logic                         clk_in,
    output logic      [adla_pkg::N_ADDR-1:0]  addr_out,
    output logic                              top_out,
    output logic      [adla_pkg::N_PAGE-1:0]  page_out,
    output logic                              rd_out,
    output logic                              wr_out,
    output logic                              ale_out,
    output logic      [adla_pkg::N_PORTC-1:0] portc_out,
    output logic      [adla_pkg::N_BYTE-1:0]  porta_out,
    output logic      [adla_pkg::N_BYTE-1:0]  ad_out
);
    import adla_pkg::*;
    logic [N_BYTE-1:0] ad_val_reg = 8'h00;
    logic              ad_drive_reg = 1'b0;
    logic [N_BYTE-1:0] idle_reg = 8'h55;

    // Released bus shows a pattern that flips every cycle, never the old value
    always @(posedge clk_in) begin
        idle_reg <= ~idle_reg;
    end
    assign ad_out = ad_drive_reg ? ad_val_reg : idle_reg;

    initial begin
        {addr_out, top_out, page_out, rd_out, wr_out, ale_out, portc_out, porta_out} = '0;
    end

    // One bus state: address, page, strobes and byte lanes change together
    task automatic drive(input logic [4:0] a, input logic tp, input logic [3:0] pg, input logic r,
                         input logic w, input logic l, input logic [2:0] pc, input logic [7:0] pa,
                         input logic adv, input logic [7:0] ad);
        addr_out     = a;
        top_out      = tp;
        page_out     = pg;
        rd_out       = r;
        wr_out       = w;
        ale_out      = l;
        portc_out    = pc;
        porta_out    = pa;
        ad_drive_reg = adv;
        ad_val_reg   = ad;
    endtask
endmodule
